// *** hw/mipr_regs.sv ***
// identification and first pin mode register slice with the pin's function logic
// assumes boot load and interrupt level come from logic on the same clock; pins are async
`timescale 1ns/1ps
`default_nettype none
module mipr_regs
    import mipr_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_I,
    // serial host port
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output var  logic        SDA_O,
    output var  logic        SDA_OE_O,
    // boot load from nonvolatile memory
    input  wire logic        NVM_LOAD_I,
    input  wire logic [7:0]  NVM_DAY_PHASE_I,
    input  wire logic [15:0] NVM_TIME_I,
    // interrupt level from the ranging core, active high
    input  wire logic        RANGE_INT_I,
    // first general pin
    input  wire logic        FIRST_GENERAL_PIN_I,
    output var  logic        FIRST_GENERAL_PIN_O,
    output var  logic        FIRST_GENERAL_PIN_OE_O,
    // shutdown request to the device, active high
    output var  logic        SHUTDOWN_O
);

    logic [15:0] reg_addr;
    logic [7:0]  wr_data;
    logic        wr_stb;
    logic [7:0]  rd_data;
    logic        sda_o_w;
    logic        sda_oe_w;

    logic [7:0]  day_phase_q, day_phase_d;
    logic [15:0] time_q, time_d;
    logic [7:0]  mode_q, mode_d;
    logic [1:0]  pin_sync_q;            // [0] read only by [1]
    logic        pin_out_q, pin_out_d;
    logic        pin_oe_q, pin_oe_d;
    logic        shutdown_q, shutdown_d;

    logic        pin0_shutdown_priority;
    logic        pin0_polarity;
    logic [3:0]  pin0_function_select;

    // address decode shared by the read mux and the write path
    function automatic mipr_sel_t reg_sel(input logic [15:0] addr);
        case (addr)
            ADDR_DAY_PHASE: reg_sel = SEL_DAY_PHASE;
            ADDR_TIME_HI:   reg_sel = SEL_TIME_HI;
            ADDR_TIME_LO:   reg_sel = SEL_TIME_LO;
            ADDR_PIN_MODE:  reg_sel = SEL_PIN_MODE;
            default:        reg_sel = SEL_NONE;
        endcase
    endfunction

    // serial front end
    mipr_serial_port u_port (
        .clk_i      (SYS_CLK_I),
        .rst_i      (RST_I),
        .scl_i      (SCL_I),
        .sda_i      (SDA_I),
        .sda_o      (sda_o_w),
        .sda_oe_o   (sda_oe_w),
        .reg_addr_o (reg_addr),
        .wr_data_o  (wr_data),
        .wr_stb_o   (wr_stb),
        .rd_data_i  (rd_data)
    );

    // mode fields
    assign pin0_shutdown_priority = mode_q[MODE_PRIO_BIT];
    assign pin0_polarity          = mode_q[MODE_POL_BIT];
    assign pin0_function_select   = mode_q[MODE_SEL_MSB:MODE_SEL_LSB];

    // read mux; time is high byte first, unmapped reads return zero
    always_comb
    begin
        case (reg_sel(reg_addr))
            SEL_DAY_PHASE: rd_data = day_phase_q;
            SEL_TIME_HI:   rd_data = time_q[15:8];
            SEL_TIME_LO:   rd_data = time_q[7:0];
            SEL_PIN_MODE:  rd_data = mode_q;
            default:       rd_data = RD_UNMAPPED;
        endcase
    end

    // register writes; the boot load wins over a host write in the same cycle
    always_comb
    begin
        day_phase_d = day_phase_q;
        time_d      = time_q;
        mode_d      = mode_q;
        if (wr_stb)
        begin
            case (reg_sel(reg_addr))
                SEL_DAY_PHASE: day_phase_d = wr_data;
                SEL_TIME_HI:   time_d = {wr_data, time_q[7:0]};
                SEL_TIME_LO:   time_d = {time_q[15:8], wr_data};
                SEL_PIN_MODE:  mode_d = wr_data & MODE_WR_MASK;
                default:       ;
            endcase
        end
        if (NVM_LOAD_I)
        begin
            day_phase_d = NVM_DAY_PHASE_I;
            time_d      = NVM_TIME_I;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            day_phase_q <= RST_DAY_PHASE;
            time_q      <= RST_TIME;
            mode_q      <= RST_PIN_MODE;
        end
        else
        begin
            day_phase_q <= day_phase_d;
            time_q      <= time_d;
            mode_q      <= mode_d;
        end
    end

    // pin function; priority mode ignores polarity and select so a stray write cannot
    // turn the shutdown input into an output
    always_comb
    begin
        pin_out_d  = 1'b0;
        pin_oe_d   = 1'b0;
        shutdown_d = 1'b0;
        if (pin0_shutdown_priority)
        begin
            shutdown_d = ~pin_sync_q[1];    // shutdown input is active low
        end
        else
        begin
            case (pin0_function_select)
                SEL_INT_OUT:
                begin
                    pin_out_d = pin0_polarity ? RANGE_INT_I : ~RANGE_INT_I;
                    pin_oe_d  = 1'b1;
                end
                SEL_OFF:  pin_oe_d = 1'b0;  // high impedance
                default:  pin_oe_d = 1'b0;  // undefined codes stay off the pin
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            pin_sync_q <= 2'h3;
            pin_out_q  <= 1'b0;
            pin_oe_q   <= 1'b0;
            shutdown_q <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[0], FIRST_GENERAL_PIN_I};
            pin_out_q  <= pin_out_d;
            pin_oe_q   <= pin_oe_d;
            shutdown_q <= shutdown_d;
        end
    end

    // outputs from flops here and in the port, except SDA_O, which is tied low
    assign SDA_O                  = sda_o_w;
    assign SDA_OE_O               = sda_oe_w;
    assign FIRST_GENERAL_PIN_O    = pin_out_q;
    assign FIRST_GENERAL_PIN_OE_O = pin_oe_q;
    assign SHUTDOWN_O             = shutdown_q;

endmodule // mipr_regs
`default_nettype wire

// *** hw/mipr_serial_port.sv ***
// serial host port slave: 7-bit address, 16-bit register index, byte data with auto-increment
// assumes scl/sda arrive asynchronously; open-drain sda, enable high pulls the line low
`timescale 1ns/1ps
`default_nettype none
module mipr_serial_port
    import mipr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output var  logic        sda_o,
    output var  logic        sda_oe_o,
    // register side
    output var  logic [15:0] reg_addr_o,
    output var  logic [7:0]  wr_data_o,
    output var  logic        wr_stb_o,
    input  wire logic [7:0]  rd_data_i
);

    mipr_state_t state_q, state_d;
    logic [2:0]  scl_q, sda_q;      // [0] first stage, read only by [1]
    logic [3:0]  bit_cnt_q, bit_cnt_d;
    logic [7:0]  shift_q, shift_d;
    logic [15:0] index_q, index_d;
    logic [7:0]  wdat_q, wdat_d;
    logic        ack_q, ack_d;
    logic        read_q, read_d;
    logic        more_q, more_d;
    logic        oe_q, oe_d;
    logic        stb_q, stb_d;
    logic        rise, fall, start, stop;

    // bus events from the settled stages only
    assign rise  = scl_q[1] & ~scl_q[2];
    assign fall  = ~scl_q[1] & scl_q[2];
    assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

    // byte engine; sda only changes after scl falls so the master sees stable data
    always_comb
    begin
        state_d   = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d   = shift_q;
        index_d   = index_q;
        wdat_d    = wdat_q;
        ack_d     = ack_q;
        read_d    = read_q;
        more_d    = more_q;
        oe_d      = oe_q;
        stb_d     = 1'b0;
        if (start)
        begin
            state_d   = PH_ADDR;
            bit_cnt_d = 4'h0;
            ack_d     = 1'b0;
            oe_d      = 1'b0;
        end
        else if (stop)
        begin
            state_d = PH_IDLE;
            oe_d    = 1'b0;
        end
        else
        begin
            case (state_q)
                PH_IDLE:
                begin
                    oe_d = 1'b0;
                end
                PH_RDATA:
                begin
                    if (rise && bit_cnt_q == BITS_PER_BYTE)
                    begin
                        more_d = ~sda_q[1];              // master ack asks for the next byte
                        if (sda_q[1])
                            state_d = PH_IDLE;
                        index_d = index_q + 16'h0001;
                    end
                    else if (fall && bit_cnt_q == BITS_PER_BYTE && more_q)
                    begin
                        shift_d   = rd_data_i;
                        oe_d      = ~rd_data_i[7];
                        bit_cnt_d = 4'h0;
                        more_d    = 1'b0;
                    end
                    else if (fall && bit_cnt_q < BITS_PER_BYTE)
                    begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                        shift_d   = {shift_q[6:0], 1'b0};
                        oe_d      = (bit_cnt_q == 4'h7) ? 1'b0 : ~shift_q[6];
                    end
                end
                default:
                begin
                    // receive states: address, index high, index low, write data
                    if (rise && bit_cnt_q < BITS_PER_BYTE)
                    begin
                        shift_d   = {shift_q[6:0], sda_q[1]};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                    else if (fall && bit_cnt_q == BITS_PER_BYTE && !ack_q)
                    begin
                        ack_d = 1'b1;
                        oe_d  = 1'b1;
                        case (state_q)
                            PH_ADDR:
                            begin
                                read_d = shift_q[0];
                                if (shift_q[7:1] != DEV_ADDR)
                                begin
                                    state_d = PH_IDLE;   // not ours: stay off the line
                                    ack_d   = 1'b0;
                                    oe_d    = 1'b0;
                                end
                            end
                            PH_IDX_HI: index_d = {shift_q, index_q[7:0]};
                            PH_IDX_LO: index_d = {index_q[15:8], shift_q};
                            PH_WDATA:
                            begin
                                wdat_d = shift_q;
                                stb_d  = 1'b1;
                            end
                            default: ;
                        endcase
                    end
                    else if (fall && ack_q)
                    begin
                        ack_d     = 1'b0;
                        oe_d      = 1'b0;
                        bit_cnt_d = 4'h0;
                        case (state_q)
                            PH_ADDR:
                            begin
                                if (read_q)
                                begin
                                    state_d = PH_RDATA;
                                    shift_d = rd_data_i;
                                    oe_d    = ~rd_data_i[7];
                                end
                                else
                                    state_d = PH_IDX_HI;
                            end
                            PH_IDX_HI: state_d = PH_IDX_LO;
                            PH_IDX_LO: state_d = PH_WDATA;
                            PH_WDATA:  index_d = index_q + 16'h0001;
                            default:   state_d = PH_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // registers; index survives between transfers so a read can follow an index write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_q     <= 3'h7;
            sda_q     <= 3'h7;
            state_q   <= PH_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            index_q   <= 16'h0000;
            wdat_q    <= 8'h00;
            ack_q     <= 1'b0;
            read_q    <= 1'b0;
            more_q    <= 1'b0;
            oe_q      <= 1'b0;
            stb_q     <= 1'b0;
        end
        else
        begin
            scl_q     <= {scl_q[1:0], scl_i};
            sda_q     <= {sda_q[1:0], sda_i};
            state_q   <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q   <= shift_d;
            index_q   <= index_d;
            wdat_q    <= wdat_d;
            ack_q     <= ack_d;
            read_q    <= read_d;
            more_q    <= more_d;
            oe_q      <= oe_d;
            stb_q     <= stb_d;
        end
    end

    // open-drain: level is always low, only the enable moves
    assign sda_o      = 1'b0;
    assign sda_oe_o   = oe_q;
    assign reg_addr_o = index_q;
    assign wr_data_o  = wdat_q;
    assign wr_stb_o   = stb_q;

endmodule // mipr_serial_port
`default_nettype wire

// *** pkg/mipr_pkg.sv ***
// constants for the module identification and first pin mode register slice
// assumes a byte-wide register space reached through the serial host port, 16-bit index
// How it works
// - low date register holds day in bits 7..3 and phase in bits 2..0
// - date and time registers together form one unique module identity set
// - sixteen-bit time register over two byte addresses; seconds since midnight = value * 2
// - shutdown priority bit set means all other mode bits are ignored
// - priority bit 1 makes the pin the main shutdown input; 0 follows function
// - mode bit 5 selects pin polarity: 0 active-low, 1 active-high
// - mode bits 4..1 pick function: 0000 high impedance, 1000 interrupt output
// - at boot nonvolatile contents replace the identification register defaults
package mipr_pkg;

    // register byte addresses
    localparam logic [15:0] ADDR_DAY_PHASE  = 16'h0007;
    localparam logic [15:0] ADDR_TIME_HI    = 16'h0008;
    localparam logic [15:0] ADDR_TIME_LO    = 16'h0009;
    localparam logic [15:0] ADDR_PIN_MODE   = 16'h0010;

    // day/phase field layout
    localparam int          DAY_MSB         = 7;
    localparam int          DAY_LSB         = 3;
    localparam int          PHASE_MSB       = 2;
    localparam int          PHASE_LSB       = 0;

    // seconds per time count
    localparam int          TIME_SEC_PER_LSB = 2;

    // pin mode field layout
    localparam int          MODE_PRIO_BIT   = 6;
    localparam int          MODE_POL_BIT    = 5;
    localparam int          MODE_SEL_MSB    = 4;
    localparam int          MODE_SEL_LSB    = 1;
    localparam int          MODE_RSVD_BIT   = 0;
    localparam logic [7:0]  MODE_WR_MASK    = 8'h7F;   // bit 7 is read-only zero

    // pin function codes
    localparam logic [3:0]  SEL_OFF         = 4'h0;
    localparam logic [3:0]  SEL_INT_OUT     = 4'h8;

    // reset values and the unmapped read value; identification defaults are overwritten by the boot load
    localparam logic [7:0]  RST_PIN_MODE    = 8'h60;
    localparam logic [7:0]  RST_DAY_PHASE   = 8'h00;
    localparam logic [15:0] RST_TIME        = 16'h0000;
    localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

    // serial port: 7-bit device address, value arbitrary
    localparam logic [6:0]  DEV_ADDR        = 7'h2A;
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

    // register selector
    typedef enum {
        SEL_NONE,
        SEL_DAY_PHASE,
        SEL_TIME_HI,
        SEL_TIME_LO,
        SEL_PIN_MODE
    } mipr_sel_t;

    // serial engine states
    typedef enum {
        PH_IDLE,
        PH_ADDR,
        PH_IDX_HI,
        PH_IDX_LO,
        PH_WDATA,
        PH_RDATA
    } mipr_state_t;

endpackage

// *** verif/mipr_host_model.sv ***
// host side of the serial port: bit-banged master with register read and write tasks
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module mipr_host_model
    import mipr_pkg::*;
(
    // clock and line
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    // eight system clocks per half bit, twice the minimum for margin
    localparam int HALF = 8;

    // bus idle: clock high, data released
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // start or repeated start; data is released while the clock is low, then pulled low with the clock high
    task automatic start_c();
        wait_n(2);
        sda_low_o = 1'b0;
        wait_n(HALF);
        scl_o = 1'b1;
        wait_n(HALF);
        sda_low_o = 1'b1;
        wait_n(HALF);
        scl_o = 1'b0;
    endtask

    task automatic stop_c();
        wait_n(2);
        sda_low_o = 1'b1;
        wait_n(HALF);
        scl_o = 1'b1;
        wait_n(HALF);
        sda_low_o = 1'b0;
        wait_n(HALF);
    endtask

    // one bit out and the line sampled late in the high phase
    task automatic bit_c(input logic b, output logic r);
        wait_n(2);
        sda_low_o = !b;
        wait_n(HALF);
        scl_o = 1'b1;
        wait_n(HALF);
        r = sda_i;
        scl_o = 1'b0;
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic byte_c(input logic [7:0] d, input logic a_in, output logic [7:0] r, output logic a_out);
        for (int i = 7; i >= 0; i--)
            bit_c(d[i], r[i]);
        bit_c(a_in, a_out);
    endtask

    // address phase plus 16-bit index; ok is low if any byte was not acknowledged
    task automatic set_idx(input logic [6:0] dev, input logic [15:0] idx, output logic ok);
        logic [7:0] r;
        logic       a;
        start_c();
        byte_c({dev, 1'b0}, 1'b1, r, a);
        ok = !a;
        byte_c(idx[15:8], 1'b1, r, a);
        ok &= !a;
        byte_c(idx[7:0], 1'b1, r, a);
        ok &= !a;
    endtask

    task automatic wr(input logic [6:0] dev, input logic [15:0] idx, input int n, input logic [15:0] d,
                      output logic ok);
        logic [7:0] r;
        logic       a;
        set_idx(dev, idx, ok);
        for (int i = n - 1; i >= 0; i--)
        begin
            byte_c(d[8*i +: 8], 1'b1, r, a);
            ok &= !a;
        end
        stop_c();
    endtask

    // last byte is refused so the device lets go of the line
    task automatic rd(input logic [15:0] idx, input int n, output logic [15:0] d);
        logic ok;
        logic a;
        d = 16'h0000;
        set_idx(DEV_ADDR, idx, ok);
        start_c();
        byte_c({DEV_ADDR, 1'b1}, 1'b1, d[15:8], a);
        d = 16'h0000;
        for (int i = n - 1; i >= 0; i--)
            byte_c(8'hFF, i == 0, d[8*i +: 8], a);
        stop_c();
    endtask
endmodule // mipr_host_model
`default_nettype wire

// *** verif/mipr_regs_sva.sv ***
// checker for the pin function and serial line behaviour of the register slice
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module mipr_regs_sva
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // serial pins
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    // first general pin
    input wire logic RANGE_INT_I,
    input wire logic FIRST_GENERAL_PIN_I,
    input wire logic FIRST_GENERAL_PIN_O,
    input wire logic FIRST_GENERAL_PIN_OE_O,
    input wire logic SHUTDOWN_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    // pin driven for two cycles in a row
    sequence s_drive2;
        FIRST_GENERAL_PIN_OE_O [*2];
    endsequence

    // shutdown in force and the pin was low two cycles back in the pipe
    sequence s_prio_low;
        SHUTDOWN_O && !$past(FIRST_GENERAL_PIN_I, 2);
    endsequence

    a_shut_pin_low: assert property (SHUTDOWN_O |-> !$past(FIRST_GENERAL_PIN_I, 3))
        else $error("shutdown high without the pin low three cycles before");
    a_shut_hold: assert property (s_prio_low |=> SHUTDOWN_O)
        else $error("shutdown dropped while the pin stayed low");
    a_prio_no_drive: assert property (SHUTDOWN_O |-> !FIRST_GENERAL_PIN_OE_O)
        else $error("pin driven while it serves as shutdown input");
    // polarity fixed while driving, so output and interrupt keep one relation
    a_int_track: assert property (s_drive2 |-> (FIRST_GENERAL_PIN_O ^ $past(RANGE_INT_I))
        == ($past(FIRST_GENERAL_PIN_O) ^ $past(RANGE_INT_I, 2)))
        else $error("pin output does not follow the interrupt level");
    a_reset_quiet: assert property (@(posedge SYS_CLK_I) disable iff (1'b0)
        RST_I |=> !SDA_OE_O && !FIRST_GENERAL_PIN_OE_O && !SHUTDOWN_O)
        else $error("outputs active just after reset");
    a_ack_scl_low: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I))
        else $error("data line changed while the serial clock was high");
    a_ack_stands: assert property ($rose(SDA_OE_O) |-> SDA_OE_O [*4])
        else $error("data line pull shorter than four cycles");
    a_sda_open: assert property (!SDA_O)
        else $error("data line driven high");
endmodule // mipr_regs_sva
`default_nettype wire

// *** verif/mipr_regs_test.sv ***
// self-checking bench for the identification and first pin mode register slice
// assumes the host model drives the serial pins; the bench resolves both two-way lines
`timescale 1ns/1ps
`default_nettype none
module mipr_regs_test
    import mipr_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        host_scl;
    logic        host_low;
    wire logic   sda_w;
    logic        sda_oe;
    logic        sda_o;
    logic        nvm_load;
    logic [7:0]  nvm_dp;
    logic [15:0] nvm_time;
    logic        range_int;
    logic        pin_ext;
    wire logic   pin_w;
    logic        pin_o;
    logic        pin_oe;
    logic        shutdown;
    int          err_total;
    int          checks;

    // open drain with pull-up; the pin shows the device only while it drives
    assign sda_w = !(host_low || (sda_oe && !sda_o));
    assign pin_w = pin_oe ? pin_o : pin_ext;

    mipr_regs u_dut
    (
        .SYS_CLK_I(clk), .RST_I(rst), .SCL_I(host_scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
        .NVM_LOAD_I(nvm_load), .NVM_DAY_PHASE_I(nvm_dp), .NVM_TIME_I(nvm_time), .RANGE_INT_I(range_int),
        .FIRST_GENERAL_PIN_I(pin_w), .FIRST_GENERAL_PIN_O(pin_o), .FIRST_GENERAL_PIN_OE_O(pin_oe),
        .SHUTDOWN_O(shutdown)
    );

    mipr_host_model u_host
    (
        .clk_i(clk), .sda_i(sda_w), .scl_o(host_scl), .sda_low_o(host_low)
    );

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: register got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: pin got %h expected %h", $time, got, exp);
        end
    endtask

    // register write must be acknowledged; outputs settle a few cycles after
    task automatic wr(input logic [15:0] idx, input int n, input logic [15:0] d);
        logic ok;
        u_host.wr(DEV_ADDR, idx, n, d, ok);
        cmp_pin(ok, 1'b1);
        wait_n(6);
    endtask

    task automatic rd(input logic [15:0] idx, input int n, input logic [15:0] exp);
        logic [15:0] got;
        u_host.rd(idx, n, got);
        cmp_reg(got, exp);
    endtask

    // reset value, then the shutdown input tracks the pin inverted
    task automatic t_boot();
        rd(ADDR_PIN_MODE, 1, 16'h0060);
        cmp_pin(shutdown, 1'b1);
        pin_ext = 1'b1;
        wait_n(5);
        cmp_pin(shutdown, 1'b0);
        cmp_pin(pin_oe, 1'b0);
    endtask

    // boot load replaces the identification defaults
    task automatic t_nvm();
        nvm_dp = {5'h15, 3'h3};
        nvm_time = 16'h1234;
        nvm_load = 1'b1;
        wait_n(1);
        nvm_load = 1'b0;
        rd(ADDR_DAY_PHASE, 1, {8'h00, 5'h15, 3'h3});
        rd(ADDR_TIME_HI, 2, 16'h1234);
    endtask

    // field extremes, auto-increment across the time pair, halves kept apart
    task automatic t_ids();
        wr(ADDR_DAY_PHASE, 1, {8'h00, 5'h1F, 3'h0});
        rd(ADDR_DAY_PHASE, 1, 16'h00F8);
        wr(ADDR_TIME_HI, 2, 16'hBEEF);
        rd(ADDR_TIME_LO, 1, 16'h00EF);
        wr(ADDR_TIME_LO, 1, 16'h0001);
        rd(ADDR_TIME_HI, 2, 16'hBE01);
    endtask

    // priority set: function and polarity bits have no effect, bit 7 reads zero
    task automatic t_prio();
        wr(ADDR_PIN_MODE, 1, 16'h00F0);
        rd(ADDR_PIN_MODE, 1, 16'h0070);
        cmp_pin(pin_oe, 1'b0);
        pin_ext = 1'b0;
        wait_n(5);
        cmp_pin(shutdown, 1'b1);
        pin_ext = 1'b1;
        wait_n(5);
    endtask

    // both polarities on the interrupt function, off in between
    task automatic t_func();
        for (int p = 0; p < 2; p++)
        begin
            wr(ADDR_PIN_MODE, 1, {8'h00, 2'b00, p[0], SEL_INT_OUT, 1'b0});
            cmp_pin(pin_oe, 1'b1);
            cmp_pin(shutdown, 1'b0);
            for (int v = 0; v < 2; v++)
            begin
                range_int = v[0];
                wait_n(3);
                cmp_pin(pin_o, p[0] ? v[0] : !v[0]);
            end
            wr(ADDR_PIN_MODE, 1, {8'h00, 2'b00, p[0], SEL_OFF, 1'b0});
            cmp_pin(pin_oe, 1'b0);
        end
    endtask

    // foreign device address ignored, unmapped index reads zero
    task automatic t_refuse();
        logic ok;
        u_host.wr(7'h2B, ADDR_PIN_MODE, 1, 16'h0050, ok);
        cmp_pin(ok, 1'b0);
        rd(ADDR_PIN_MODE, 1, 16'h0020);
        u_host.wr(DEV_ADDR, 16'h0020, 1, 16'h0055, ok);
        cmp_pin(ok, 1'b1);
        rd(16'h0020, 1, {8'h00, RD_UNMAPPED});
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // 100 ns clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // whole run is some 16k cycles; the limit is close to four times that
    initial
    begin
        #6_000_000;
        err_total++;
        summarize();
    end

    initial
    begin
        err_total = 0;
        checks = 0;
        rst = 1'b1;
        nvm_load = 1'b0;
        nvm_dp = 8'h00;
        nvm_time = 16'h0000;
        range_int = 1'b0;
        pin_ext = 1'b0;
        wait_n(4);
        rst = 1'b0;
        wait_n(6);
        t_boot();
        t_nvm();
        t_ids();
        t_prio();
        t_func();
        t_refuse();
        summarize();
    end
endmodule // mipr_regs_test

bind mipr_regs mipr_regs_sva u_sva
(
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
    .RANGE_INT_I(RANGE_INT_I), .FIRST_GENERAL_PIN_I(FIRST_GENERAL_PIN_I),
    .FIRST_GENERAL_PIN_O(FIRST_GENERAL_PIN_O), .FIRST_GENERAL_PIN_OE_O(FIRST_GENERAL_PIN_OE_O),
    .SHUTDOWN_O(SHUTDOWN_O)
);
`default_nettype wire
